/* File: bench/pbgpio_chk.sv */
// Purpose: port-level checks of pad drive and read data
// Assumes: clk_en high, pad outputs one edge behind their causes
// Notes: bound to every port instance
`timescale 1ns/1ps
module pbgpio_chk (
	// clock, reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// observed ports
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pad_pullup,
	input wire logic serial_if_enable,
	input wire logic serial_if_master_select,
	input wire logic serial_clock_out,
	input wire logic serial_master_data_out,
	input wire logic timer1_compare_a_out,
	input wire logic timer1_compare_a_enable,
	input wire logic timer2_compare_a_out,
	input wire logic timer2_compare_a_enable,
	input wire logic clock_out_option,
	input wire logic divided_clock_out,
	input wire logic internal_rc_selected,
	input wire logic external_clock_selected,
	input wire logic async_timer_enable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// serial block held in one mode for two edges
	sequence s_slave; (serial_if_enable && !serial_if_master_select) [*2]; endsequence
	sequence s_master; (serial_if_enable && serial_if_master_select) [*2]; endsequence
	a_reset_tristate: assert property (disable iff (1'b0)
		!rst_n |-> pad_oe[7:1] == 7'h00 && pad_pullup == 8'h00) else $error("pin driven in reset");
	a_clock_out: assert property (disable iff (1'b0)
		clock_out_option |-> pad_oe[0] && pad_out[0] == divided_clock_out) else $error("no clock out");
	a_slave_forced_in: assert property (s_slave |-> (pad_oe & 8'h2C) == 8'h00)
		else $error("slave pin driven");
	a_master_miso_in: assert property (s_master |-> !pad_oe[4])
		else $error("master-in pin driven");
	a_master_clock: assert property (s_master |-> pad_out[5] == $past(serial_clock_out))
		else $error("serial clock not on pin");
	a_bit3_value: assert property ((serial_if_enable && serial_if_master_select)
		|=> pad_out[3] == $past(serial_master_data_out | timer2_compare_a_out))
		else $error("bit 3 value wrong");
	a_compare_a: assert property (timer1_compare_a_enable
		|=> pad_out[1] == $past(timer1_compare_a_out)) else $error("compare a value wrong");
	a_osc_released: assert property (((!internal_rc_selected && !external_clock_selected)
		|| async_timer_enable) [*2] |-> !pad_oe[7] && !pad_pullup[7]) else $error("bit 7 held");
	a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read");
endmodule : pbgpio_chk
bind pbgpio_port pbgpio_chk i_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
	.serial_if_enable(serial_if_enable), .serial_if_master_select(serial_if_master_select),
	.serial_clock_out(serial_clock_out), .serial_master_data_out(serial_master_data_out),
	.timer1_compare_a_out(timer1_compare_a_out),
	.timer1_compare_a_enable(timer1_compare_a_enable),
	.timer2_compare_a_out(timer2_compare_a_out),
	.timer2_compare_a_enable(timer2_compare_a_enable),
	.clock_out_option(clock_out_option), .divided_clock_out(divided_clock_out),
	.internal_rc_selected(internal_rc_selected),
	.external_clock_selected(external_clock_selected),
	.async_timer_enable(async_timer_enable)
);

/* File: bench/pbgpio_pads.sv */
// Purpose: outside circuit on the eight port pins
// Assumes: own drive wins, then outside drive, then pull-up
// Notes: a pin nobody holds toggles every cycle
`timescale 1ns/1ps
module pbgpio_pads (
	// clock for the floating pattern
	input wire logic ref_clk,
	// design pad side
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pad_pullup,
	// outside drivers steered by the bench
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	// resolved pin level
	output logic [7:0] pad_in
);
	// floating pattern register
	logic [7:0] float_r = 8'h55;
	always_ff @(posedge ref_clk) begin
		float_r <= ~float_r;
	end
	// resolve each pin in priority order
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i]) pad_in[i] = pad_out[i];
			else if (ext_en[i]) pad_in[i] = ext_val[i];
			else if (pad_pullup[i]) pad_in[i] = 1'b1;
			else pad_in[i] = float_r[i];
		end
	end
endmodule : pbgpio_pads

/* File: bench/pbgpio_port_test.sv */
// Purpose: register-driven tests of the port and its overrides
// Assumes: reads answer in the next cycle, pads one edge behind
// Notes: clock-out option is set through reset
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module pbgpio_port_test
	import pbgpio_pkg::*;
;
	// design inputs
	logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sleep = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, ext_en = 8'hFF, ext_val = 8'h00;
	logic serial_if_enable = 1'b0, serial_if_master_select = 1'b0, serial_clock_out = 1'b0;
	logic serial_master_data_out = 1'b0, serial_slave_data_out = 1'b0;
	logic timer1_compare_a_out = 1'b0, timer1_compare_a_enable = 1'b0, timer1_compare_b_out = 1'b0;
	logic timer1_compare_b_enable = 1'b0, timer2_compare_a_out = 1'b0, timer2_compare_a_enable = 1'b0;
	logic clock_out_option = 1'b1, divided_clock_out = 1'b1, internal_rc_selected = 1'b0;
	logic external_clock_selected = 1'b0, async_timer_enable = 1'b0;
	// design outputs
	logic [7:0] reg_rdata, pad_in, pad_out, pad_oe, pad_pullup, pin_change_level;
	logic serial_clock_in, serial_slave_data_in, serial_master_data_in, serial_select_active;
	logic timer1_capture_in;
	int num_errors = 0, checks = 0;
	pbgpio_port i_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
		.sleep(sleep),
		.serial_if_enable(serial_if_enable), .serial_if_master_select(serial_if_master_select),
		.serial_clock_out(serial_clock_out), .serial_master_data_out(serial_master_data_out),
		.serial_slave_data_out(serial_slave_data_out), .serial_clock_in(serial_clock_in),
		.serial_slave_data_in(serial_slave_data_in),
		.serial_master_data_in(serial_master_data_in),
		.serial_select_active(serial_select_active),
		.timer1_compare_a_out(timer1_compare_a_out),
		.timer1_compare_a_enable(timer1_compare_a_enable),
		.timer1_compare_b_out(timer1_compare_b_out),
		.timer1_compare_b_enable(timer1_compare_b_enable),
		.timer2_compare_a_out(timer2_compare_a_out),
		.timer2_compare_a_enable(timer2_compare_a_enable),
		.timer1_capture_in(timer1_capture_in),
		.clock_out_option(clock_out_option), .divided_clock_out(divided_clock_out),
		.internal_rc_selected(internal_rc_selected),
		.external_clock_selected(external_clock_selected),
		.async_timer_enable(async_timer_enable),
		.pin_change_level(pin_change_level)
	);
	pbgpio_pads i_pads (
		.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
		.ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
	);
	always #50 ref_clk = ~ref_clk;
	task automatic report_and_stop();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask : rd
	// let changes reach the pads
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : settle
	// watchdog far beyond the test length
	initial begin
		#1000000;
		num_errors++;
		report_and_stop();
	end
	initial begin
		settle(2);
		`CHK(pad_oe, 8'h01)
		@(posedge ref_clk) begin
			rst_n <= 1'b1;
			clock_out_option <= 1'b0;
		end
		for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
		wr(PBG_OFF_DIRECTION, 8'hFF);
		wr(PBG_OFF_OUTPUT_VALUE, 8'hA5);
		settle(2);
		`CHK(pad_oe, 8'h7F)
		@(posedge ref_clk) external_clock_selected <= 1'b1;
		settle(2);
		`CHK(pad_oe, 8'hFF)
		`CHK(pad_out, 8'hA5)
		@(posedge ref_clk) begin
			timer1_compare_a_enable <= 1'b1;
			timer1_compare_a_out <= 1'b1;
			timer1_compare_b_enable <= 1'b1;
			timer2_compare_a_enable <= 1'b1;
			timer2_compare_a_out <= 1'b1;
		end
		settle(2);
		`CHK(pad_out[3:1], 3'h5)
		// master: serial clock on bit 5, master-in released
		@(posedge ref_clk) begin
			timer2_compare_a_out <= 1'b0;
			serial_if_enable <= 1'b1;
			serial_if_master_select <= 1'b1;
			serial_master_data_out <= 1'b1;
		end
		settle(2);
		`CHK(pad_oe, 8'hEF)
		`CHK(pad_out[5], 1'b0)
		// slave: forced inputs keep their pull-ups
		@(posedge ref_clk) serial_if_master_select <= 1'b0;
		wr(PBG_OFF_OUTPUT_VALUE, 8'h2C);
		settle(2);
		`CHK(pad_oe, 8'hD3)
		`CHK(pad_pullup, 8'h2C)
		wr(PBG_OFF_CONTROL, 8'h02);
		settle(4);
		`CHK(pad_pullup, 8'h00)
		`CHK(serial_select_active, 1'b1)
		@(posedge ref_clk) begin
			serial_if_enable <= 1'b0;
			ext_val <= 8'h29;
		end
		wr(PBG_OFF_DIRECTION, 8'h00);
		settle(4);
		rd(PBG_OFF_INPUT, 8'h29);
		`CHK(timer1_capture_in, 1'b1)
		`CHK(pin_change_level, 8'h29)
		`CHK(serial_clock_in, 1'b1)
		`CHK(serial_master_data_in, 1'b0)
		`CHK(serial_select_active, 1'b0)
		// sleep gates inputs unless a pin-change source is armed
		@(posedge ref_clk) sleep <= 1'b1;
		wr(PBG_OFF_CHANGE_MASK, 8'h0C);
		wr(PBG_OFF_CONTROL, 8'hFF);
		settle(4);
		rd(PBG_OFF_INPUT, 8'h08);
		`CHK(serial_slave_data_in, 1'b1)
		`CHK(serial_clock_in, 1'b0)
		`CHK(timer1_capture_in, 1'b0)
		rd(PBG_OFF_CONTROL, 8'h03);
		// a frozen clock enable drops a write
		@(posedge ref_clk) clk_en <= 1'b0;
		wr(PBG_OFF_DIRECTION, 8'hFF);
		@(posedge ref_clk) clk_en <= 1'b1;
		rd(PBG_OFF_DIRECTION, 8'h00);
		// reset in mid-run releases driven pins at once
		wr(PBG_OFF_DIRECTION, 8'hFF);
		settle(2);
		`CHK(pad_oe, 8'hFF)
		@(posedge ref_clk) rst_n <= 1'b0;
		#1 `CHK(pad_oe, 8'h00)
		@(posedge ref_clk) rst_n <= 1'b1;
		rd(PBG_OFF_DIRECTION, 8'h00);
		// released pin 1 rises through its pull-up
		@(posedge ref_clk) begin
			sleep <= 1'b0;
			ext_en <= 8'hFD;
		end
		wr(PBG_OFF_OUTPUT_VALUE, 8'h02);
		settle(4);
		rd(PBG_OFF_INPUT, 8'h2B);
		report_and_stop();
	end
endmodule : pbgpio_port_test

/* File: core/pbgpio_pkg.sv */
// Purpose: shared constants for the eight-bit port with alternate-function overrides
// Assumes: register port with 3-bit address and 8-bit data
// Notes: offsets below are word indices on the plain register port
package pbgpio_pkg;
	// data path width of one port
	localparam int PBG_WIDTH = 8;
	// register address width
	localparam int PBG_AW = 3;

	// register offsets
	localparam logic [2:0] PBG_OFF_INPUT = 3'h0;
	localparam logic [2:0] PBG_OFF_DIRECTION = 3'h1;
	localparam logic [2:0] PBG_OFF_OUTPUT_VALUE = 3'h2;
	localparam logic [2:0] PBG_OFF_CHANGE_MASK = 3'h3;
	localparam logic [2:0] PBG_OFF_CONTROL = 3'h4;

	// control register field positions
	localparam int PBG_CTL_GROUP_EN_BIT = 0;
	localparam int PBG_CTL_PULLUP_DIS_BIT = 1;
	// writable bits of the control register
	localparam logic [7:0] PBG_CTL_MASK = 8'h03;

	// values after reset
	localparam logic [7:0] PBG_RST_DIRECTION = 8'h00;
	localparam logic [7:0] PBG_RST_OUTPUT_VALUE = 8'h00;
	localparam logic [7:0] PBG_RST_CHANGE_MASK = 8'h00;
	localparam logic [7:0] PBG_RST_CONTROL = 8'h00;
	localparam logic [7:0] PBG_RST_ZERO = 8'h00;

	// pin positions of the alternate functions
	localparam int PBG_BIT_CLKOUT = 0;
	localparam int PBG_BIT_CMP_A = 1;
	localparam int PBG_BIT_SEL = 2;
	localparam int PBG_BIT_MOSI = 3;
	localparam int PBG_BIT_MISO = 4;
	localparam int PBG_BIT_SCK = 5;
	localparam int PBG_BIT_OSC_IN = 6;
	localparam int PBG_BIT_OSC_OUT = 7;

	// input synchroniser depth in cycles
	localparam int PBG_SYNC_STAGES = 2;
endpackage : pbgpio_pkg

/* File: core/pbgpio_port.sv */
// Purpose: eight-bit general I/O port with per-pin alternate-function overrides
// Assumes: one clock, pins sampled as asynchronous inputs through a two-stage synchroniser, peripherals drive plain levels
// Notes: pin 0 and its enable bypass the output flops while the clock-out option is set
`timescale 1ns/1ps
module pbgpio_port
	import pbgpio_pkg::*;
(
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// register port
	input wire logic [PBG_AW-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// pads
	input wire logic [7:0] pad_in,
	output logic [7:0] pad_out,
	output logic [7:0] pad_oe,
	output logic [7:0] pad_pullup,
	// shared system levels
	input wire logic sleep,
	// serial interface
	input wire logic serial_if_enable,
	input wire logic serial_if_master_select,
	input wire logic serial_clock_out,
	input wire logic serial_master_data_out,
	input wire logic serial_slave_data_out,
	output logic serial_clock_in,
	output logic serial_slave_data_in,
	output logic serial_master_data_in,
	output logic serial_select_active,
	// timers
	input wire logic timer1_compare_a_out,
	input wire logic timer1_compare_a_enable,
	input wire logic timer1_compare_b_out,
	input wire logic timer1_compare_b_enable,
	input wire logic timer2_compare_a_out,
	input wire logic timer2_compare_a_enable,
	output logic timer1_capture_in,
	// clock and oscillator configuration
	input wire logic clock_out_option,
	input wire logic divided_clock_out,
	input wire logic internal_rc_selected,
	input wire logic external_clock_selected,
	input wire logic async_timer_enable,
	// pin-change levels
	output logic [7:0] pin_change_level
);

	// direction register
	logic [7:0] direction_register_r;
	// output value register
	logic [7:0] output_value_register_r;
	// pin-change source mask
	logic [7:0] change_mask_r;
	// group enable and global pull-up disable
	logic [7:0] control_r;
	// read data, valid one cycle after strobe
	logic [7:0] rdata_r;
	// first synchroniser stage, read only by second
	logic [7:0] sync_meta_r;
	// second synchroniser stage
	logic [7:0] sync_r;
	// gated input levels
	logic [7:0] input_register_r;
	// registered pad drive value
	logic [7:0] pad_out_r;
	// registered pad output enable, high drives
	logic [7:0] pad_oe_r;
	// registered pull-up enable, never high with drive
	logic [7:0] pad_pullup_r;
	// registered slave-select decode
	logic select_active_r;
	// keeps the bit 0 pull-up off while the clock is driven out
	logic [7:0] clkout_pull_mask;

	// shared control levels
	logic pin_change_group_enable;
	logic global_pullup_disable;
	// per-pin override terms
	// pull-up override
	logic [7:0] pullup_override_enable;
	logic [7:0] pullup_override_value;
	// direction override, the forced value is always input
	logic [7:0] direction_override_enable;
	logic [7:0] direction_override_value;
	// pin value override from peripherals
	logic [7:0] pin_value_override_enable;
	logic [7:0] pin_value_override_value;
	// digital input buffer override
	logic [7:0] input_buffer_override_enable;
	logic [7:0] input_buffer_override_value;
	// resolved per-pin next values
	// direction, one drives the pin
	logic [7:0] dir_nxt;
	// drive value
	logic [7:0] val_nxt;
	// pull-up before masking by the drive
	logic [7:0] pull_nxt;
	// input buffer enable
	logic [7:0] die_nxt;
	// serial mode decodes
	logic spi_slave;
	logic spi_master;
	// oscillator pin decodes
	logic osc7_claim;
	logic osc6_claim;

	// control register fields
	assign pin_change_group_enable = control_r[PBG_CTL_GROUP_EN_BIT];
	assign global_pullup_disable = control_r[PBG_CTL_PULLUP_DIS_BIT];
	// serial mode decodes, both low while the interface is off
	assign spi_slave = serial_if_enable & ~serial_if_master_select;
	assign spi_master = serial_if_enable & serial_if_master_select;
	assign clkout_pull_mask = clock_out_option ? 8'hfe : 8'hff;
	assign osc7_claim = (~internal_rc_selected & ~external_clock_selected) | async_timer_enable;
	assign osc6_claim = internal_rc_selected | async_timer_enable;

	// alternate-function override terms for every pin
	always_comb begin
		// no override unless a function claims the pin
		pullup_override_enable = 8'h00;
		pullup_override_value = 8'h00;
		direction_override_enable = 8'h00;
		direction_override_value = 8'h00;
		pin_value_override_enable = 8'h00;
		pin_value_override_value = 8'h00;
		input_buffer_override_enable = change_mask_r & {8{pin_change_group_enable}};
		input_buffer_override_value = 8'hff;
		pullup_override_enable[PBG_BIT_OSC_OUT] = osc7_claim;
		direction_override_enable[PBG_BIT_OSC_OUT] = osc7_claim;
		input_buffer_override_enable[PBG_BIT_OSC_OUT] = osc7_claim
			| (change_mask_r[PBG_BIT_OSC_OUT] & pin_change_group_enable);
		input_buffer_override_value[PBG_BIT_OSC_OUT] =
			(internal_rc_selected | external_clock_selected) & async_timer_enable;
		pullup_override_enable[PBG_BIT_OSC_IN] = osc6_claim;
		direction_override_enable[PBG_BIT_OSC_IN] = osc6_claim;
		input_buffer_override_enable[PBG_BIT_OSC_IN] = osc6_claim
			| (change_mask_r[PBG_BIT_OSC_IN] & pin_change_group_enable);
		input_buffer_override_value[PBG_BIT_OSC_IN] = internal_rc_selected & ~async_timer_enable;
		pullup_override_enable[PBG_BIT_SCK] = spi_slave;
		direction_override_enable[PBG_BIT_SCK] = spi_slave;
		pin_value_override_enable[PBG_BIT_SCK] = spi_master;
		pin_value_override_value[PBG_BIT_SCK] = serial_clock_out;
		pullup_override_enable[PBG_BIT_MISO] = spi_master;
		direction_override_enable[PBG_BIT_MISO] = spi_master;
		pin_value_override_enable[PBG_BIT_MISO] = spi_slave;
		pin_value_override_value[PBG_BIT_MISO] = serial_slave_data_out;
		pullup_override_enable[PBG_BIT_MOSI] = spi_slave;
		direction_override_enable[PBG_BIT_MOSI] = spi_slave;
		pin_value_override_enable[PBG_BIT_MOSI] = spi_master | timer2_compare_a_enable;
		pin_value_override_value[PBG_BIT_MOSI] = serial_master_data_out | timer2_compare_a_out;
		pullup_override_enable[PBG_BIT_SEL] = spi_slave;
		direction_override_enable[PBG_BIT_SEL] = spi_slave;
		pin_value_override_enable[PBG_BIT_SEL] = timer1_compare_b_enable;
		pin_value_override_value[PBG_BIT_SEL] = timer1_compare_b_out;
		pin_value_override_enable[PBG_BIT_CMP_A] = timer1_compare_a_enable;
		pin_value_override_value[PBG_BIT_CMP_A] = timer1_compare_a_out;
		pullup_override_value[PBG_BIT_SCK] =
			output_value_register_r[PBG_BIT_SCK] & ~global_pullup_disable;
		pullup_override_value[PBG_BIT_MISO] =
			output_value_register_r[PBG_BIT_MISO] & ~global_pullup_disable;
		pullup_override_value[PBG_BIT_MOSI] =
			output_value_register_r[PBG_BIT_MOSI] & ~global_pullup_disable;
		pullup_override_value[PBG_BIT_SEL] =
			output_value_register_r[PBG_BIT_SEL] & ~global_pullup_disable;
	end

	// per-pin resolution of direction, value, pull-up and buffer enable
	genvar gi;
	generate
		for (gi = 0; gi < PBG_WIDTH; gi++) begin : g_pin
			assign dir_nxt[gi] = direction_override_enable[gi] ? direction_override_value[gi]
				: direction_register_r[gi];
			assign val_nxt[gi] = pin_value_override_enable[gi] ? pin_value_override_value[gi]
				: output_value_register_r[gi];
			assign pull_nxt[gi] = pullup_override_enable[gi] ? pullup_override_value[gi]
				: (output_value_register_r[gi] & ~direction_register_r[gi]
				& ~global_pullup_disable);
			assign die_nxt[gi] = input_buffer_override_enable[gi]
				? input_buffer_override_value[gi] : ~sleep;
		end
	endgenerate

	// register writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			direction_register_r <= PBG_RST_DIRECTION;
			output_value_register_r <= PBG_RST_OUTPUT_VALUE;
			change_mask_r <= PBG_RST_CHANGE_MASK;
			control_r <= PBG_RST_CONTROL;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				// direction bits
				PBG_OFF_DIRECTION: direction_register_r <= reg_wdata;
				// output-value bits
				PBG_OFF_OUTPUT_VALUE: output_value_register_r <= reg_wdata;
				// pin-change source mask
				PBG_OFF_CHANGE_MASK: change_mask_r <= reg_wdata;
				// only group enable and pull-up disable stick
				PBG_OFF_CONTROL: control_r <= reg_wdata & PBG_CTL_MASK;
				// input register and unmapped ignore writes
				default: begin
				end
			endcase
		end
	end

	// read data for exactly one cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= PBG_RST_ZERO;
		end else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					PBG_OFF_INPUT: rdata_r <= input_register_r;
					// stored registers echo back
					PBG_OFF_DIRECTION: rdata_r <= direction_register_r;
					PBG_OFF_OUTPUT_VALUE: rdata_r <= output_value_register_r;
					PBG_OFF_CHANGE_MASK: rdata_r <= change_mask_r;
					PBG_OFF_CONTROL: rdata_r <= control_r;
					// unmapped reads as zero
					default: rdata_r <= PBG_RST_ZERO;
				endcase
			end else begin
				// no read this cycle, so the data return to zero
				rdata_r <= PBG_RST_ZERO;
			end
		end
	end

	// pin input synchroniser and buffer gating
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_meta_r <= PBG_RST_ZERO;
			sync_r <= PBG_RST_ZERO;
			input_register_r <= PBG_RST_ZERO;
		end else if (clk_en) begin
			// first stage may go metastable
			sync_meta_r <= pad_in;
			// second stage is the only reader of the first
			sync_r <= sync_meta_r;
			input_register_r <= sync_r & die_nxt;
		end
	end

	// pad drive flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_out_r <= PBG_RST_ZERO;
			pad_oe_r <= PBG_RST_ZERO;
			pad_pullup_r <= PBG_RST_ZERO;
		end else if (clk_en) begin
			// value after overrides
			pad_out_r <= val_nxt;
			pad_oe_r <= dir_nxt;
			pad_pullup_r <= pull_nxt & ~dir_nxt & clkout_pull_mask;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			// no slave is selected in reset
			select_active_r <= 1'b0;
		end else if (clk_en) begin
			// same edge as the input register, so both agree
			select_active_r <= spi_slave & ~(sync_r[PBG_BIT_SEL] & die_nxt[PBG_BIT_SEL]);
		end
	end

	always_comb begin
		// registered drive by default
		pad_out = pad_out_r;
		pad_oe = pad_oe_r;
		// combinational, so the clock also leaves in reset
		if (clock_out_option) begin
			pad_out[PBG_BIT_CLKOUT] = divided_clock_out;
			pad_oe[PBG_BIT_CLKOUT] = 1'b1;
		end
	end

	// registered pad and bus outputs
	assign pad_pullup = pad_pullup_r;
	assign reg_rdata = rdata_r;
	assign pin_change_level = input_register_r;
	// alternate inputs to peripherals
	assign serial_clock_in = input_register_r[PBG_BIT_SCK];
	assign serial_slave_data_in = input_register_r[PBG_BIT_MOSI];
	assign serial_master_data_in = input_register_r[PBG_BIT_MISO];
	assign serial_select_active = select_active_r;
	assign timer1_capture_in = input_register_r[PBG_BIT_CLKOUT];

endmodule : pbgpio_port
